// File: bench/rsbi_bus_if_tb.sv
// rsbi_bus_if_tb: self-checking bench for the system bus interface.
// assumes one phase clock drives all logic; the memory model answers data ops.
module rsbi_bus_if_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam rsbi_pkg::rsbi_kind_e FE = rsbi_pkg::XFER_FETCH, LD = rsbi_pkg::XFER_LOAD;
	localparam rsbi_pkg::rsbi_kind_e ST = rsbi_pkg::XFER_STORE, AT = rsbi_pkg::XFER_ATOMIC;
	localparam rsbi_pkg::rsbi_kind_e FP = rsbi_pkg::XFER_FPOP;
	logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, irq_take = 1'b0, rett_fault = 1'b0;
	logic psr_load = 1'b0, psr_s = 1'b0, psr_et = 1'b0, null_cycle = 1'b0, err_arm = 1'b0;
	logic adr_en_n = 1'b0, alt_en_n = 1'b0, data_en_n = 1'b0, bus_grant_hold_n = 1'b1;
	logic coprocessor_hold = 1'b0, coprocessor_error = 1'b0;
	logic [3:0] interrupt_level_bus = 4'h0;
	logic [1:0] wlen = 2'h0, wsel = 2'h0;
	rsbi_pkg::rsbi_req_s req = '0;
	rsbi_pkg::rsbi_rsp_s rsp;
	logic        ready, rsp_valid, sup_o, et_o, rtrap, addr_oe, rd, atomic_flag, lock, alt_oe;
	logic        data_drive_enable_n, addr_latch_hold, we_n, dflag, mds_n, memory_error_n;
	logic [7:0]  tt, space_identifier;
	logic [1:0]  size;
	logic [3:0]  memory_wait_hold;
	logic [31:0] addr, dout, mdata, bus, rnd = 32'ha9653964, r0, r1;
	logic [31:0] sh [64];
	logic        sup, e0;
	int          num_errors = 0, comparisons = 0;
	// one phase clock of the pair; 40 ns period
	always #20 clk = ~clk;
	assign bus = data_drive_enable_n ? dout : mdata;
	rsbi_bus_if u_rsbi_bus_if (.i_ref_clk(clk), .i_rst(rst), .i_req_valid(req_valid),
		.i_req(req), .o_req_ready(ready), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
		.i_irq_take(irq_take), .i_rett_fault(rett_fault), .i_psr_load(psr_load),
		.i_psr_s(psr_s), .i_psr_et(psr_et), .i_interrupt_level_bus(interrupt_level_bus),
		.o_trap_type_field(tt), .o_supervisor(sup_o), .o_trap_enable_bit(et_o),
		.o_reset_trap(rtrap), .o_addr(addr), .o_addr_oe(addr_oe), .o_space_identifier(space_identifier),
		.o_read(rd), .o_size(size), .o_atomic_flag(atomic_flag), .o_bus_lock(lock),
		.o_alt_oe(alt_oe), .o_data(dout), .o_data_oe(data_drive_enable_n), .i_data(bus),
		.o_addr_latch_hold(addr_latch_hold), .o_write_strobe_n(we_n), .o_data_transfer_flag(dflag),
		.i_null_cycle(null_cycle), .i_mem_data_strobe_n(mds_n),
		.i_addr_drive_enable_n(adr_en_n), .i_alt_drive_enable_n(alt_en_n),
		.i_data_drive_enable_n(data_en_n), .i_memory_wait_hold(memory_wait_hold),
		.i_bus_grant_hold_n(bus_grant_hold_n), .i_coprocessor_hold(coprocessor_hold),
		.i_coprocessor_error(coprocessor_error), .i_memory_error_n(memory_error_n));
	rsbi_mem_model u_rsbi_mem_model (.i_ref_clk(clk), .i_addr(addr), .i_read(rd),
		.i_atomic(atomic_flag),
		.i_write_strobe_n(we_n), .i_bus(bus), .i_xfer_flag(dflag), .i_wait_len(wlen),
		.i_wait_sel(wsel), .i_err_arm(err_arm), .o_rdata(mdata), .o_memory_wait_hold(memory_wait_hold),
		.o_mem_data_strobe_n(mds_n), .o_memory_error_n(memory_error_n));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [7:0] exp_asi(input rsbi_pkg::rsbi_kind_e k);
		if (k == FE)
			return sup ? rsbi_pkg::ASI_SUPV_INSTR : rsbi_pkg::ASI_USER_INSTR;
		return sup ? rsbi_pkg::ASI_SUPV_DATA : rsbi_pkg::ASI_USER_DATA;
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic summarize();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// address and alt enables wander at random so their drive gating is exercised all run
	always @(posedge clk) begin
		rnd <= lfsr(rnd);
		adr_en_n <= rnd[3];
		alt_en_n <= rnd[7];
		// rare coprocessor errors cut store strobes
		coprocessor_error <= rnd[12] & rnd[13] & rnd[14];
	end
	always @(negedge clk) begin
		if (!rst) begin
			chk("addr_oe", !adr_en_n, addr_oe);
			chk("alt_oe", !alt_en_n, alt_oe);
			if (data_en_n) chk("data_oe", 0, data_drive_enable_n);
			if (|memory_wait_hold) chk("hal_memory_wait_hold", 1, addr_latch_hold);
		end
	end
	task automatic rst_seq();
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		sup = 1'b1;
		// first edge that sees reset low enters the reset trap
		@(posedge clk);
		@(negedge clk);
		chk("reset_trap", 1, rtrap);
		chk("sup", 1, sup_o);
		chk("et", 0, et_o);
		@(negedge clk);
		chk("boot_addr", rsbi_pkg::RESET_VECTOR, addr);
		chk("boot_asi", rsbi_pkg::ASI_SUPV_INSTR, space_identifier);
	endtask
	task automatic processor_state_reg(input logic s, input logic et);
		@(posedge clk);
		psr_load <= 1'b1;
		psr_s <= s;
		psr_et <= et;
		sup = s;
		@(posedge clk);
		psr_load <= 1'b0;
	endtask
	task automatic irq(input logic [3:0] lv);
		@(posedge clk);
		interrupt_level_bus <= lv;
		irq_take <= 1'b1;
		@(posedge clk);
		irq_take <= 1'b0;
		@(negedge clk);
	endtask
	task automatic op(input rsbi_pkg::rsbi_kind_e k, input logic [1:0] sz,
			input logic [31:0] a, input logic [31:0] wd);
		int t, n, nb;
		logic we, dbl;
		t = 0;
		n = 0;
		we = 1'b0;
		e0 = 1'b0;
		dbl = (sz == rsbi_pkg::SIZE_DOUBLE);
		nb = (dbl || k == AT) ? 2 : 1;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{kind: k, size: sz, addr: a, wdata: wd};
		@(negedge clk);
		while (ready !== 1'b1 && t < 50) begin
			@(negedge clk);
			t++;
		end
		chk("taken", 1, t < 50);
		@(posedge clk);
		req_valid <= 1'b0;
		@(negedge clk);
		chk("addr", a, addr);
		if (k != FE && k != FP) chk("read", k == LD, rd);
		chk("size", sz, size);
		chk("asi", exp_asi(k), space_identifier);
		chk("lock", k == ST || k == AT || (k == LD && dbl), lock);
		chk("atomic_flag", k == AT, atomic_flag);
		chk("dflag", !null_cycle && k != FE && k != FP, dflag);
		chk("doe", k == ST && !data_en_n, data_drive_enable_n);
		for (t = 0; t < 40 && n < nb && !e0; t++) begin
			@(negedge clk);
			if (t == 0) chk("dflag_len", 0, dflag);
			if (coprocessor_hold === 1'b1) chk("we_coprocessor_hold", 1, we_n);
			if (t == 1) coprocessor_hold <= 1'b0;
			if (we_n === 1'b0) we = 1'b1;
			if (rsp_valid === 1'b1) begin
				if (n == 0) r0 = rsp.rdata;
				else r1 = rsp.rdata;
				e0 = (rsp.err === 1'b1);
				n++;
			end
		end
		chk("wstrobe", (k == ST || k == AT) && !e0, we);
		if (!e0) chk("beats", nb, n);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		summarize();
	end
	initial begin
		rsbi_pkg::rsbi_kind_e k;
		logic [1:0]  sz;
		logic [31:0] a, r;
		for (int i = 0; i < 64; i++) begin
			sh[i] = 32'hc3a50000 ^ (i * 32'h00010203);
			u_rsbi_mem_model.mem[i] = sh[i];
		end
		rst_seq();
		for (int lv = 1; lv < 16; lv++) begin
			processor_state_reg(1'b1, 1'b1);
			irq(lv[3:0]);
			chk("tt_irq", {rsbi_pkg::TT_IRQ_HI, lv[3:0]}, tt);
		end
		processor_state_reg(1'b1, 1'b0);
		irq(4'h5);
		chk("tt_masked", 8'h1f, tt);
		processor_state_reg(1'b0, 1'b1);
		@(posedge clk);
		rst_seq();
		chk("tt_kept", 8'h1f, tt);
		@(posedge clk);
		rett_fault <= 1'b1;
		@(posedge clk);
		rett_fault <= 1'b0;
		rst_seq();
		chk("tt_rett", rsbi_pkg::TT_RETT_ERR, tt);
		op(FE, rsbi_pkg::SIZE_WORD, 32'h8, 32'h0);
		op(FP, rsbi_pkg::SIZE_WORD, 32'hc, 32'h0);
		op(LD, rsbi_pkg::SIZE_DOUBLE, 32'h20, 32'h0);
		chk("ldd0", sh[8], r0);
		chk("ldd1", sh[9], r1);
		op(AT, rsbi_pkg::SIZE_BYTE, 32'h30, 32'hdeadbeef);
		chk("atomic_old", sh[12], r0);
		sh[12] = 32'hdeadbeef;
		null_cycle <= 1'b1;
		op(ST, rsbi_pkg::SIZE_HALF, 32'h40, 32'h0badf00d);
		null_cycle <= 1'b0;
		sh[16] = 32'h0badf00d;
		err_arm <= 1'b1;
		op(LD, rsbi_pkg::SIZE_WORD, 32'h44, 32'h0);
		err_arm <= 1'b0;
		chk("mem_err", 1, e0);
		data_en_n <= 1'b1;
		op(ST, rsbi_pkg::SIZE_WORD, 32'h48, 32'h1);
		data_en_n <= 1'b0;
		op(ST, rsbi_pkg::SIZE_WORD, 32'h48, sh[18]);
		@(posedge clk);
		bus_grant_hold_n <= 1'b0;
		@(negedge clk);
		chk("bus_grant_hold_ready", 0, ready);
		chk("bus_grant_hold_hal", 1, addr_latch_hold);
		@(posedge clk);
		bus_grant_hold_n <= 1'b1;
		coprocessor_hold <= 1'b1;
		op(ST, rsbi_pkg::SIZE_WORD, 32'h4c, 32'h5a5a5a5a);
		sh[19] = 32'h5a5a5a5a;
		chk("coprocessor_hold_store", sh[19], u_rsbi_mem_model.mem[19]);
		processor_state_reg(1'b0, 1'b0);
		for (int i = 0; i < 40; i++) begin
			r = rnd;
			k = r[0] ? ST : LD;
			sz = r[2:1];
			if (k == ST && sz == rsbi_pkg::SIZE_DOUBLE) sz = rsbi_pkg::SIZE_WORD;
			a = {24'h0, r[7:3], 3'h0};
			wlen <= r[9:8];
			wsel <= r[11:10];
			op(k, sz, a, ~r);
			if (k == ST) sh[a[7:2]] = ~r;
			else chk("load", sh[a[7:2]], r0);
			if (k == LD && sz == rsbi_pkg::SIZE_DOUBLE) chk("load2", sh[a[7:2] + 6'h1], r1);
		end
		summarize();
	end
endmodule

// File: bench/rsbi_mem_model.sv
// rsbi_mem_model: behavioural memory controller on the far side of the system bus.
// assumes the bench resolves the data bus and drives the wait and error knobs.
module rsbi_mem_model (
	input  wire logic        i_ref_clk,           // phase clock a
	input  wire logic [31:0] i_addr,              // address bus
	input  wire logic        i_read,              // read indicator
	input  wire logic        i_atomic,            // atomic op, load beat first
	input  wire logic        i_write_strobe_n,    // write strobe, low
	input  wire logic [31:0] i_bus,               // resolved data bus
	input  wire logic        i_xfer_flag,         // data transfer start
	input  wire logic [1:0]  i_wait_len,          // wait cycles per data op
	input  wire logic [1:0]  i_wait_sel,          // which hold line
	input  wire logic        i_err_arm,           // fail next data op
	output logic [31:0]      o_rdata,             // memory data drive
	output logic [3:0]       o_memory_wait_hold,  // hold lines
	output logic             o_mem_data_strobe_n, // data valid, low
	output logic             o_memory_error_n     // error, low
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [64];
	logic [1:0]  cnt   = 2'h0;
	logic [31:0] last  = 32'h0;
	logic        err_n = 1'b1;
	// everything sampled on phase clock a
	always @(posedge i_ref_clk) begin
		// stores land only under the strobe
		if (!i_write_strobe_n)
			mem[i_addr[7:2]] <= i_bus;
		// wait states counted from the transfer start
		// an armed error also holds one cycle, so the error lands in a data cycle
		if (i_xfer_flag)
			cnt <= i_wait_len | {1'b0, i_err_arm};
		else if (cnt != 2'h0)
			cnt <= cnt - 2'h1;
		// one-cycle error in the data cycle
		err_n <= !(i_xfer_flag && i_err_arm);
		last <= o_rdata;
	end
	// data stands whole read; strobe only in last hold cycle
	// atomics keep the read indicator low, so the atomic flag also reads
	assign o_rdata             = (i_read || i_atomic) ? mem[i_addr[7:2]] : ~last;
	assign o_memory_wait_hold  = (cnt != 2'h0) ? (4'h1 << i_wait_sel) : 4'h0;
	assign o_mem_data_strobe_n = !(cnt == 2'h1 && (i_read || i_atomic));
	assign o_memory_error_n    = err_n;
	// this controller never claims the bus, so never after a lock
endmodule

// File: rtl/rsbi_bus_if.sv
// rsbi_bus_if: system bus interface, reset trap entry and interrupt trap typing.
// assumes the core issues one request at a time and that bus inputs meet the
// setup window of i_ref_clk (phase clock a); tristate wires are resolved outside.
module rsbi_bus_if (
	input  wire logic                       i_ref_clk,              // phase clock a
	input  wire logic                       i_rst,                  // sync reset, high
	input  wire logic                       i_req_valid,            // core request valid
	input  wire rsbi_pkg::rsbi_req_s        i_req,                  // core request
	output logic                            o_req_ready,            // request taken
	output logic                            o_rsp_valid,            // beat finished
	output rsbi_pkg::rsbi_rsp_s             o_rsp,                  // read data / error
	input  wire logic                       i_irq_take,             // core takes interrupt
	input  wire logic                       i_rett_fault,           // rett with traps off, user
	input  wire logic                       i_psr_load,             // core writes s/et
	input  wire logic                       i_psr_s,                // new supervisor bit
	input  wire logic                       i_psr_et,               // new trap enable bit
	input  wire logic [rsbi_pkg::IRL_W-1:0] i_interrupt_level_bus,  // interrupt level
	output logic [rsbi_pkg::TT_W-1:0]       o_trap_type_field,      // trap type
	output logic                            o_supervisor,           // supervisor bit
	output logic                            o_trap_enable_bit,      // trap enable bit
	output logic                            o_reset_trap,           // reset trap pulse
	output logic [rsbi_pkg::ADDR_W-1:0]     o_addr,                 // address bus
	output logic                            o_addr_oe,              // address drive on
	output logic [rsbi_pkg::ASI_W-1:0]      o_space_identifier,     // space identifier
	output logic                            o_read,                 // read indicator
	output logic [1:0]                      o_size,                 // transfer width
	output logic                            o_atomic_flag,          // atomic op
	output logic                            o_bus_lock,             // bus lock
	output logic                            o_alt_oe,               // alt group drive on
	output logic [rsbi_pkg::DATA_W-1:0]     o_data,                 // data bus out
	output logic                            o_data_oe,              // data drive on
	input  wire logic [rsbi_pkg::DATA_W-1:0] i_data,                // data bus in
	output logic                            o_addr_latch_hold,      // stop address latch
	output logic                            o_write_strobe_n,       // write strobe, low
	output logic                            o_data_transfer_flag,   // data op start
	input  wire logic                       i_null_cycle,           // null cycle
	input  wire logic                       i_mem_data_strobe_n,    // data valid, low
	input  wire logic                       i_addr_drive_enable_n,  // address enable, low
	input  wire logic                       i_alt_drive_enable_n,   // alt enable, low
	input  wire logic                       i_data_drive_enable_n,  // data enable, low
	input  wire logic [rsbi_pkg::HOLD_N-1:0] i_memory_wait_hold,    // memory holds
	input  wire logic                       i_bus_grant_hold_n,     // bus hold, low
	input  wire logic                       i_coprocessor_hold,     // coprocessor hold
	input  wire logic                       i_coprocessor_error,    // coprocessor error
	input  wire logic                       i_memory_error_n        // memory error, low
);
	rsbi_pkg::rsbi_state_e state_r, state_nxt;
	rsbi_pkg::rsbi_req_s   cur_r;
	logic                  beat_r;
	logic                  mem_err_r;
	logic                  s_r, et_r, rett_fault_r;
	logic [rsbi_pkg::TT_W-1:0]   tt_r;
	logic [rsbi_pkg::DATA_W-1:0] data_cap_r;
	logic we_r, data_transfer_flag_r, lock_r, rd_r, rsp_valid_r;
	rsbi_pkg::rsbi_rsp_s   rsp_r;
	logic memory_wait_hold_any, freeze, store_beat, two_beat, last_beat, beat_done, bus_err, busy_nxt;

	function automatic logic [rsbi_pkg::ASI_W-1:0] asi_of(rsbi_pkg::rsbi_kind_e k, logic s);
		if (k == rsbi_pkg::XFER_FETCH)
			return s ? rsbi_pkg::ASI_SUPV_INSTR : rsbi_pkg::ASI_USER_INSTR;
		return s ? rsbi_pkg::ASI_SUPV_DATA : rsbi_pkg::ASI_USER_DATA;
	endfunction

	// inputs taken straight; they share phase clock a
	assign memory_wait_hold_any  = |i_memory_wait_hold;
	assign freeze     = memory_wait_hold_any | ~i_bus_grant_hold_n;
	assign store_beat = (cur_r.kind == rsbi_pkg::XFER_STORE) ||
	                    (cur_r.kind == rsbi_pkg::XFER_ATOMIC && beat_r);
	assign two_beat   = (cur_r.kind == rsbi_pkg::XFER_ATOMIC) ||
	                    (cur_r.size == rsbi_pkg::SIZE_DOUBLE);
	assign last_beat  = !two_beat || beat_r;
	// store beat waits out a coprocessor hold, and ends only once its
	// strobe has stood a cycle; a hold dropped at the closing edge would
	// otherwise finish the beat with no strobe at all
	assign beat_done  = !freeze && !(store_beat && (i_coprocessor_hold || !we_r));
	// error registered, acted on a cycle after assertion
	assign bus_err    = mem_err_r && state_r == rsbi_pkg::ST_DATA;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			// leaving reset mode runs the reset trap
			rsbi_pkg::ST_RESET: state_nxt = rsbi_pkg::ST_BOOT;
			rsbi_pkg::ST_BOOT:  state_nxt = rsbi_pkg::ST_ADDR;
			rsbi_pkg::ST_IDLE: begin
				if (i_req_valid && !freeze)
					state_nxt = rsbi_pkg::ST_ADDR;
			end
			rsbi_pkg::ST_ADDR: begin
				if (!freeze)
					state_nxt = rsbi_pkg::ST_DATA;
			end
			rsbi_pkg::ST_DATA: begin
				if (bus_err)
					state_nxt = rsbi_pkg::ST_IDLE;
				else if (beat_done)
					state_nxt = last_beat ? rsbi_pkg::ST_IDLE : rsbi_pkg::ST_ADDR;
			end
			default: state_nxt = rsbi_pkg::ST_RESET;
		endcase
	end
	assign busy_nxt = state_nxt == rsbi_pkg::ST_ADDR || state_nxt == rsbi_pkg::ST_DATA;

	// reset mode held while reset is high
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			state_r <= rsbi_pkg::ST_RESET;
		else
			state_r <= state_nxt;
	end

	// request capture and beat sequencing
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			beat_r <= 1'b0;
		end else if (state_r == rsbi_pkg::ST_BOOT) begin
			// first fetch from zero, trap base unused
			cur_r.kind  <= rsbi_pkg::XFER_FETCH;
			cur_r.size  <= rsbi_pkg::SIZE_WORD;
			cur_r.addr  <= rsbi_pkg::RESET_VECTOR;
			cur_r.wdata <= '0;
			beat_r      <= 1'b0;
		end else if (state_r == rsbi_pkg::ST_IDLE && state_nxt == rsbi_pkg::ST_ADDR) begin
			cur_r  <= i_req;
			beat_r <= 1'b0;
		end else if (state_r == rsbi_pkg::ST_DATA && state_nxt == rsbi_pkg::ST_ADDR) begin
			beat_r <= 1'b1;
			// atomic store phase reuses the address; doubles step a word
			if (cur_r.kind != rsbi_pkg::XFER_ATOMIC)
				cur_r.addr <= cur_r.addr + rsbi_pkg::WORD_STEP;
		end
	end

	// trap state: tt has no reset, it survives reset mode on purpose
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			s_r  <= 1'b1;
			et_r <= 1'b0;
		end else if (state_r == rsbi_pkg::ST_BOOT) begin
			// reset trap: supervisor on, traps off
			s_r  <= 1'b1;
			et_r <= 1'b0;
		end else if (i_irq_take && et_r) begin
			s_r  <= 1'b1;
			et_r <= 1'b0;
		end else if (i_psr_load) begin
			s_r  <= i_psr_s;
			et_r <= i_psr_et;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (state_r == rsbi_pkg::ST_BOOT) begin
			// tt kept unless a faulting return preceded
			if (rett_fault_r)
				tt_r <= rsbi_pkg::TT_RETT_ERR;
		end else if (i_irq_take && et_r && state_r != rsbi_pkg::ST_RESET) begin
			tt_r <= {rsbi_pkg::TT_IRQ_HI, i_interrupt_level_bus};
		end
	end

	// fault flag: a new fault wins over the clear at the boot step
	always_ff @(posedge i_ref_clk) begin
		if (i_rett_fault)
			rett_fault_r <= 1'b1;
		else if (i_rst)
			rett_fault_r <= rett_fault_r;
		else if (state_r == rsbi_pkg::ST_BOOT)
			rett_fault_r <= 1'b0;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			mem_err_r <= 1'b0;
		else
			mem_err_r <= ~i_memory_error_n;
	end

	// strobed data caught during a memory hold
	always_ff @(posedge i_ref_clk) begin
		if (state_r == rsbi_pkg::ST_DATA && (!i_mem_data_strobe_n || !memory_wait_hold_any))
			data_cap_r <= i_data;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rsp_valid_r <= 1'b0;
			rsp_r       <= '0;
		end else begin
			rsp_valid_r <= state_r == rsbi_pkg::ST_DATA && (bus_err || beat_done);
			rsp_r.err   <= bus_err;
			rsp_r.rdata <= memory_wait_hold_any ? data_cap_r : i_data;
		end
	end

	// bus control pins, registered so they move only on phase clock a
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			we_r     <= 1'b0;
			data_transfer_flag_r <= 1'b0;
			lock_r   <= 1'b0;
			rd_r     <= 1'b0;
		end else if (state_r == rsbi_pkg::ST_BOOT) begin
			// boot fetch: cur_r is loaded on this edge, so its kind is not usable yet
			we_r     <= 1'b0;
			data_transfer_flag_r <= 1'b0;
			lock_r   <= 1'b0;
			rd_r     <= 1'b1;
		end else begin
			// strobe withheld by hold, cut by either error
			we_r     <= state_nxt == rsbi_pkg::ST_DATA && store_beat && !i_coprocessor_hold &&
			            !i_coprocessor_error && !mem_err_r;
			// one pulse at the start of a data op, none for fetch or fpop
			data_transfer_flag_r <= state_r == rsbi_pkg::ST_IDLE && state_nxt == rsbi_pkg::ST_ADDR &&
			            i_req.kind != rsbi_pkg::XFER_FETCH &&
			            i_req.kind != rsbi_pkg::XFER_FPOP && !i_null_cycle;
			lock_r   <= busy_nxt && (state_r == rsbi_pkg::ST_IDLE ?
			            (i_req.kind == rsbi_pkg::XFER_STORE ||
			             i_req.kind == rsbi_pkg::XFER_ATOMIC ||
			             i_req.size == rsbi_pkg::SIZE_DOUBLE) :
			            (cur_r.kind == rsbi_pkg::XFER_STORE || two_beat));
			// read high for loads, low through stores and atomics
			rd_r     <= busy_nxt && (state_r == rsbi_pkg::ST_IDLE ?
			            (i_req.kind != rsbi_pkg::XFER_STORE &&
			             i_req.kind != rsbi_pkg::XFER_ATOMIC) :
			            (cur_r.kind != rsbi_pkg::XFER_STORE &&
			             cur_r.kind != rsbi_pkg::XFER_ATOMIC));
		end
	end

	assign o_addr_oe            = ~i_addr_drive_enable_n;
	// alt group drivers follow their enable
	assign o_alt_oe             = ~i_alt_drive_enable_n;
	// data drivers only for store beats with enable low
	assign o_data_oe            = ~i_data_drive_enable_n && store_beat &&
	                              (state_r == rsbi_pkg::ST_ADDR || state_r == rsbi_pkg::ST_DATA);
	// unlatched address; only the start of a bus cycle is meaningful
	assign o_addr               = cur_r.addr;
	assign o_data               = cur_r.wdata;
	assign o_space_identifier   = asi_of(cur_r.kind, s_r);
	// width code straight from the request
	assign o_size               = cur_r.size;
	assign o_atomic_flag        = lock_r && cur_r.kind == rsbi_pkg::XFER_ATOMIC;
	assign o_bus_lock           = lock_r;
	assign o_read               = rd_r;
	assign o_write_strobe_n     = ~we_r;
	assign o_data_transfer_flag = data_transfer_flag_r & ~i_null_cycle;
	// hold latch on memory hold, bus hold and first beat of two
	assign o_addr_latch_hold    = memory_wait_hold_any | ~i_bus_grant_hold_n |
	                              (state_r == rsbi_pkg::ST_DATA && !last_beat);
	assign o_req_ready          = state_r == rsbi_pkg::ST_IDLE && !freeze;
	assign o_rsp_valid          = rsp_valid_r;
	assign o_rsp                = rsp_r;
	assign o_trap_type_field    = tt_r;
	assign o_supervisor         = s_r;
	assign o_trap_enable_bit    = et_r;
	assign o_reset_trap         = state_r == rsbi_pkg::ST_BOOT;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	sequence seq_reset_exit;
		state_r == rsbi_pkg::ST_RESET ##1 state_r == rsbi_pkg::ST_BOOT;
	endsequence
	sequence seq_err_seen;
		!i_memory_error_n && state_r == rsbi_pkg::ST_DATA ##1 state_r == rsbi_pkg::ST_DATA;
	endsequence

	AST_IRQ_TT: assert property (i_irq_take && et_r &&
		!(state_r inside {rsbi_pkg::ST_RESET, rsbi_pkg::ST_BOOT}) |=>
		tt_r[3:0] == $past(i_interrupt_level_bus)) else $error("irq level not in tt");
	AST_RESET_EXIT: assert property ($fell(i_rst) |-> seq_reset_exit)
		else $error("reset release did not trap");
	AST_TT_KEEP: assert property (state_r == rsbi_pkg::ST_BOOT && !rett_fault_r |=>
		$stable(tt_r)) else $error("reset trap changed tt");
	AST_BOOT_ZERO: assert property (state_r == rsbi_pkg::ST_BOOT |=>
		state_r == rsbi_pkg::ST_ADDR && o_addr == rsbi_pkg::RESET_VECTOR)
		else $error("boot fetch not at zero");
	AST_RESET_PSR: assert property (seq_reset_exit |=> s_r && !et_r)
		else $error("reset trap psr wrong");
	AST_ASI_CODE: assert property (state_r == rsbi_pkg::ST_ADDR |->
		o_space_identifier inside {[rsbi_pkg::ASI_USER_INSTR:rsbi_pkg::ASI_SUPV_DATA]})
		else $error("bad space identifier");
	AST_WE_COPROCESSOR_HOLD: assert property (i_coprocessor_hold |=> o_write_strobe_n)
		else $error("write strobe during coprocessor hold");
	AST_WE_COPROCESSOR_ERROR: assert property (i_coprocessor_error |=> o_write_strobe_n)
		else $error("write strobe after coprocessor error");
	AST_DATA_TRANSFER_FLAG_PULSE: assert property (o_data_transfer_flag |=> !o_data_transfer_flag)
		else $error("data flag longer than a cycle");
	AST_FREEZE: assert property (memory_wait_hold_any && state_r == rsbi_pkg::ST_ADDR |=>
		state_r == rsbi_pkg::ST_ADDR) else $error("pipeline moved under hold");
	AST_MEM_ERR: assert property (seq_err_seen |=>
		state_r == rsbi_pkg::ST_IDLE && o_rsp_valid && o_rsp.err)
		else $error("memory error not reported");
	AST_DATA_OE: assert property (i_data_drive_enable_n |-> !o_data_oe)
		else $error("data driven while disabled");
endmodule

// File: rtl/rsbi_pkg.sv
// rsbi_pkg: constants, codes and carriers for the system bus interface.
// assumes every bus input is already synchronous to the phase clock a domain.
package rsbi_pkg;
	localparam int ADDR_W  = 32;
	localparam int DATA_W  = 32;
	localparam int ASI_W   = 8;
	localparam int IRL_W   = 4;
	localparam int TT_W    = 8;
	localparam int HOLD_N  = 4;

	localparam logic [ASI_W-1:0] ASI_USER_INSTR = 8'h08;
	localparam logic [ASI_W-1:0] ASI_SUPV_INSTR = 8'h09;
	localparam logic [ASI_W-1:0] ASI_USER_DATA  = 8'h0a;
	localparam logic [ASI_W-1:0] ASI_SUPV_DATA  = 8'h0b;

	localparam logic [1:0] SIZE_BYTE   = 2'h0;
	localparam logic [1:0] SIZE_HALF   = 2'h1;
	localparam logic [1:0] SIZE_WORD   = 2'h2;
	localparam logic [1:0] SIZE_DOUBLE = 2'h3;

	localparam logic [ADDR_W-1:0] RESET_VECTOR = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] WORD_STEP    = 32'h0000_0004;
	// upper nibble of interrupt trap types
	localparam logic [3:0]        TT_IRQ_HI    = 4'h1;
	// written by the next reset trap after a faulting return-from-trap
	localparam logic [TT_W-1:0]   TT_RETT_ERR  = 8'h03;

	typedef enum logic [2:0] {
		XFER_FETCH,
		XFER_LOAD,
		XFER_STORE,
		XFER_ATOMIC,
		XFER_FPOP
	} rsbi_kind_e;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_BOOT,
		ST_IDLE,
		ST_ADDR,
		ST_DATA
	} rsbi_state_e;

	typedef struct packed {
		rsbi_kind_e        kind;
		logic [1:0]        size;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} rsbi_req_s;

	typedef struct packed {
		logic              err;
		logic [DATA_W-1:0] rdata;
	} rsbi_rsp_s;
endpackage
